// File: logic/ssd_fifo.sv
// Purpose: byte fifo with valid and ready on both sides
// Assumes: single clock, synchronous reset
// Notes: depth is a parameter; flush empties it in one cycle
`timescale 1ns/1ps
module ssd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] rdPtr_ff, nxt_rdPtr;
    logic [AW-1:0] wrPtr_ff, nxt_wrPtr;
    logic [AW:0] count_ff, nxt_count;
    logic push, pop;

    assign inReady = (count_ff != (AW+1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign outData = mem_ff[rdPtr_ff];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    function automatic logic [AW-1:0] incPtr(input logic [AW-1:0] p);
        incPtr = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        nxt_rdPtr = pop ? incPtr(rdPtr_ff) : rdPtr_ff;
        nxt_wrPtr = push ? incPtr(wrPtr_ff) : wrPtr_ff;
        nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            nxt_rdPtr = '0;
            nxt_wrPtr = '0;
            nxt_count = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdPtr_ff <= '0;
            wrPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            rdPtr_ff <= nxt_rdPtr;
            wrPtr_ff <= nxt_wrPtr;
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push && !flush) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end
endmodule // ssd_fifo

// File: logic/ssd_pkg.sv
// Purpose: constants for the serial shadow data port
// Assumes: apb slave, 32-bit data, one word per register
// Notes: shadow window of sixteen aliased words
package ssd_pkg;
    localparam logic [31:0] SHADOW_BASE = 32'h5000_1140;
    localparam logic [31:0] SHADOW_11 = 32'h5000_115c;
    localparam logic [31:0] SHADOW_12 = 32'h5000_1160;
    localparam int SHADOW_COUNT = 16;
    localparam logic [31:0] CTRL_ADDR = 32'h5000_1180;
    localparam logic [31:0] STAT_ADDR = 32'h5000_1184;
    localparam int CTRL_FIFO_EN_BIT = 0;
    localparam int CTRL_IR_MODE_BIT = 1;
    localparam int CTRL_CLR_OVR_BIT = 2;
    localparam int STAT_DR_BIT = 0;
    localparam int STAT_OVR_BIT = 1;
    localparam int STAT_TX_HOLDING_EMPTY_FLAG_BIT = 5;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int FIFO_DEPTH_DEF = 16;
endpackage

// File: logic/ssd_shadow_port.sv
// Purpose: apb shadow data window onto a serial port receive and transmit path
// Assumes: framer delivers rxByte with rxStrobe, takes bytes by txValid/txReady
// Notes: control and status words sit just above the shadow window
`timescale 1ns/1ps
module ssd_shadow_port #(
    parameter int FIFO_DEPTH = ssd_pkg::FIFO_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] rxByte,
    input wire logic rxStrobe,
    output logic [7:0] txByte,
    output logic txValid,
    input wire logic txReady,
    output logic irMode,
    output logic fifoEnable,
    output logic receiveDataReady,
    output logic txHoldingEmptyFlag,
    output logic overrunError
);
    logic setup, access, hitShadow, hitCtrl, hitStat, mapped;
    logic shadowRd, shadowWr, ctrlWr;
    logic [1:0] ctrl_ff, nxt_ctrl;
    logic fifoOn;
    logic [7:0] rxHold_ff, nxt_rxHold;
    logic rxFull_ff, nxt_rxFull;
    logic [7:0] txHold_ff, nxt_txHold;
    logic txFull_ff, nxt_txFull;
    logic ovr_ff, nxt_ovr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack;
    logic [31:0] stat;
    logic rxfInReady, rxfOutValid, txfInReady, txfOutValid, flushAll;
    logic [7:0] rxfOut, txfOut;

    // word-aligned decode shared by the shadow test and the bus answer
    function automatic logic isShadow(input logic [31:0] a);
        logic [31:0] off;
        off = a - ssd_pkg::SHADOW_BASE;
        isShadow = (a >= ssd_pkg::SHADOW_BASE) && (off[1:0] == 2'b00)
                   && (off < 32'(4 * ssd_pkg::SHADOW_COUNT));
    endfunction

    // one wait state: setup, access, ack at second access edge keeps data registered
    assign setup = psel && !penable;
    assign access = psel && penable && !ack_ff;
    assign hitShadow = isShadow(paddr);
    assign hitCtrl = (paddr == ssd_pkg::CTRL_ADDR);
    assign hitStat = (paddr == ssd_pkg::STAT_ADDR);
    assign mapped = hitShadow || hitCtrl || hitStat;
    assign shadowRd = access && !pwrite && hitShadow;
    assign shadowWr = access && pwrite && hitShadow;
    assign ctrlWr = access && pwrite && hitCtrl;
    assign fifoOn = ctrl_ff[ssd_pkg::CTRL_FIFO_EN_BIT];
    assign flushAll = ctrlWr && (pwdata[ssd_pkg::CTRL_FIFO_EN_BIT] != fifoOn);

    assign pready = ack_ff;
    assign pslverr = 1'b0;
    assign prdata = rdata_ff;
    assign fifoEnable = fifoOn;
    assign irMode = ctrl_ff[ssd_pkg::CTRL_IR_MODE_BIT];
    assign overrunError = ovr_ff;
    assign receiveDataReady = fifoOn ? rxfOutValid : rxFull_ff;
    // flag clears as soon as the holding slot or fifo holds anything
    assign txHoldingEmptyFlag = fifoOn ? !txfOutValid : !txFull_ff;
    assign txByte = fifoOn ? txfOut : txHold_ff;
    // serial or infrared framing downstream picks the pin from irMode
    assign txValid = fifoOn ? txfOutValid : txFull_ff;

    ssd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxFifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .flush(flushAll),
        .inValid(rxStrobe && fifoOn),
        .inReady(rxfInReady),
        .inData(rxByte),
        .outValid(rxfOutValid),
        .outReady(shadowRd && fifoOn),
        .outData(rxfOut)
    );

    ssd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txFifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .flush(flushAll),
        .inValid(shadowWr && fifoOn), // full fifo refuses the push
        .inReady(txfInReady),
        .inData(pwdata[7:0]),
        .outValid(txfOutValid),
        .outReady(txReady && fifoOn),
        .outData(txfOut)
    );

    always_comb begin
        stat = '0;
        stat[ssd_pkg::STAT_DR_BIT] = receiveDataReady;
        stat[ssd_pkg::STAT_OVR_BIT] = ovr_ff;
        stat[ssd_pkg::STAT_TX_HOLDING_EMPTY_FLAG_BIT] = txHoldingEmptyFlag;
    end

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (ctrlWr) begin
            nxt_ctrl[ssd_pkg::CTRL_FIFO_EN_BIT] = pwdata[ssd_pkg::CTRL_FIFO_EN_BIT];
            nxt_ctrl[ssd_pkg::CTRL_IR_MODE_BIT] = pwdata[ssd_pkg::CTRL_IR_MODE_BIT];
        end
    end

    // receive holding byte with fifo off; read empties it, new byte overwrites
    always_comb begin
        nxt_rxHold = rxHold_ff;
        nxt_rxFull = rxFull_ff;
        if (shadowRd && !fifoOn) begin
            nxt_rxFull = 1'b0;
        end
        if (rxStrobe && !fifoOn) begin
            nxt_rxHold = rxByte;
            nxt_rxFull = 1'b1;
        end
        if (flushAll) begin
            nxt_rxFull = 1'b0;
        end
    end

    // transmit holding byte with fifo off; a pending byte is overwritten
    always_comb begin
        nxt_txHold = txHold_ff;
        nxt_txFull = txFull_ff;
        if (txReady && !fifoOn) begin
            nxt_txFull = 1'b0;
        end
        if (shadowWr && !fifoOn) begin
            nxt_txHold = pwdata[7:0];
            nxt_txFull = 1'b1;
        end
        if (flushAll) begin
            nxt_txFull = 1'b0;
        end
    end

    // overrun is sticky; set beats the software clear in the same cycle
    always_comb begin
        nxt_ovr = ovr_ff;
        if (ctrlWr && pwdata[ssd_pkg::CTRL_CLR_OVR_BIT]) begin
            nxt_ovr = 1'b0;
        end
        if (rxStrobe && !fifoOn && rxFull_ff && !(shadowRd)) begin
            nxt_ovr = 1'b1;
        end
        if (rxStrobe && fifoOn && !rxfInReady) begin
            nxt_ovr = 1'b1;
        end
    end

    always_comb begin
        nxt_ack = access;
        nxt_rdata = rdata_ff;
        if (setup) begin
            nxt_rdata = '0;
        end
        if (access && !pwrite) begin
            nxt_rdata = '0;
            if (hitShadow) begin
                nxt_rdata[7:0] = fifoOn ? rxfOut : rxHold_ff;
            end else if (hitCtrl) begin
                nxt_rdata[1:0] = ctrl_ff;
            end else if (hitStat) begin
                nxt_rdata = stat;
            end else if (!mapped) begin
                nxt_rdata = '0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_ff <= ssd_pkg::CTRL_RESET;
            rxHold_ff <= ssd_pkg::DATA_RESET;
            rxFull_ff <= 1'b0;
            txHold_ff <= ssd_pkg::DATA_RESET;
            txFull_ff <= 1'b0;
            ovr_ff <= 1'b0;
            rdata_ff <= '0;
            ack_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            rxHold_ff <= nxt_rxHold;
            rxFull_ff <= nxt_rxFull;
            txHold_ff <= nxt_txHold;
            txFull_ff <= nxt_txFull;
            ovr_ff <= nxt_ovr;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
        end
    end

    sequence s_rxOverwrite;
        rxStrobe && !fifoOn && rxFull_ff && !shadowRd;
    endsequence

    sequence s_apbRequest;
        setup ##1 (psel && penable);
    endsequence

    sequence s_apbAnswer;
        pready ##1 !pready;
    endsequence

    a_overwrite_flags_ovr: assert property (@(posedge clk_sys) disable iff (rst)
        s_rxOverwrite |=> ovr_ff && rxHold_ff == $past(rxByte))
        else $error("overwrite did not store byte and flag overrun");

    a_full_rx_keep: assert property (@(posedge clk_sys) disable iff (rst)
        rxStrobe && fifoOn && !rxfInReady && !flushAll |=> ovr_ff && rxfOutValid)
        else $error("full receive fifo lost contents or no overrun");

    a_read_returns_head: assert property (@(posedge clk_sys) disable iff (rst)
        shadowRd && fifoOn && rxfOutValid |=> prdata[7:0] == $past(rxfOut) && pready)
        else $error("shadow read did not return fifo head");

    a_read_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
        pready && !pwrite && hitShadow |-> prdata[31:8] == 24'h00_0000)
        else $error("shadow read upper bits not zero");

    a_write_clears_tx_holding_empty_flag: assert property (@(posedge clk_sys) disable iff (rst)
        shadowWr && !fifoOn && !flushAll && !ctrlWr |=> !txHoldingEmptyFlag)
        else $error("single write did not clear holding empty");

    a_write_overwrites: assert property (@(posedge clk_sys) disable iff (rst)
        shadowWr && !fifoOn && !flushAll |=> txHold_ff == $past(pwdata[7:0]) && txValid)
        else $error("holding byte not overwritten");

    a_full_tx_drop: assert property (@(posedge clk_sys) disable iff (rst)
        shadowWr && fifoOn && !txfInReady && !txReady && !flushAll |=> !txfInReady)
        else $error("full transmit fifo changed on dropped write");

    a_tx_out_path: assert property (@(posedge clk_sys) disable iff (rst)
        txValid && !txReady && !flushAll && !(shadowWr && !fifoOn)
        |=> txValid && txByte == $past(txByte))
        else $error("transmit byte changed while stalled");

    a_alias_decode: assert property (@(posedge clk_sys) disable iff (rst)
        psel && (paddr == ssd_pkg::SHADOW_11 || paddr == ssd_pkg::SHADOW_12) |-> hitShadow)
        else $error("shadow alias not decoded");

    a_ack_timing: assert property (@(posedge clk_sys) disable iff (rst)
        s_apbRequest |=> s_apbAnswer)
        else $error("apb answer timing wrong");
endmodule // ssd_shadow_port

// File: verif/ssd_far_model.sv
// Purpose: far-side framer model for the shadow port
// Assumes: takes a byte at each edge with txValid and txReady
// Notes: rxByte shows the inverse of the last byte between strobes
`timescale 1ns/1ps
module ssd_far_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic stall,
    input wire logic [7:0] txByte,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] rxByte,
    output logic rxStrobe
);
    logic [7:0] got[$];
    initial begin
        rxByte = 8'hff;
        rxStrobe = 1'b0;
    end
    // stall holds bytes back so the holding path can be filled
    assign txReady = !stall && !rst;
    always @(posedge clk_sys) begin
        if (txValid && txReady) got.push_back(txByte);
    end
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        rxByte <= b;
        rxStrobe <= 1'b1;
        @(posedge clk_sys);
        rxStrobe <= 1'b0;
        rxByte <= ~b;
        // let the taking edge settle so callers see the updated flags
        @(posedge clk_sys);
    endtask
endmodule // ssd_far_model

// File: verif/tb_serial_shadow_data_port.sv
// Purpose: self-checking bench for the shadow data port
// Assumes: apb master waits for pready; fifo depth cut to 4
// Notes: expected values come from the constants only
`timescale 1ns/1ps
module tb_serial_shadow_data_port;
    localparam int DEP = 4;
    localparam logic [31:0] BASE = ssd_pkg::SHADOW_BASE;
    localparam logic [31:0] CTRL = ssd_pkg::CTRL_ADDR;
    localparam logic [31:0] STAT = ssd_pkg::STAT_ADDR;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, txValid, txReady, rxStrobe, irMode, fifoEnable;
    logic receiveDataReady, txHoldingEmptyFlag, overrunError;
    logic [7:0] txByte, rxByte;
    logic stall = 1'b0;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    always #4 clk_sys = ~clk_sys;
    ssd_shadow_port #(.FIFO_DEPTH(DEP)) i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxByte(rxByte), .rxStrobe(rxStrobe),
        .txByte(txByte), .txValid(txValid), .txReady(txReady), .irMode(irMode),
        .fifoEnable(fifoEnable), .receiveDataReady(receiveDataReady),
        .txHoldingEmptyFlag(txHoldingEmptyFlag), .overrunError(overrunError));
    ssd_far_model i_far (.clk_sys(clk_sys), .rst(rst), .stall(stall), .txByte(txByte),
        .txValid(txValid), .txReady(txReady), .rxByte(rxByte), .rxStrobe(rxStrobe));
    task automatic give_verdict();
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard: the whole run needs well under two thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // pready ends this wait; only the hang guard ends it if pready never comes
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk("prdata", e, r);
    endtask
    task automatic wait_empty();
        while (txHoldingEmptyFlag !== 1'b1) begin
            @(posedge clk_sys);
        end
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        rdc(STAT, 32'h0000_0020);
        rdc(CTRL, 32'h0000_0000);
        rdc(32'h5000_1190, 32'h0000_0000);
        chk("pslverr", 32'h0, {31'h0, pslverr});
    endtask
    task automatic t_rx_off();
        i_far.send(8'ha5);
        rdc(STAT, 32'h0000_0021);
        rdc(ssd_pkg::SHADOW_11, 32'h0000_00a5);
        chk("ready", 32'h0, {31'h0, receiveDataReady});
        i_far.send(8'h11);
        i_far.send(8'h22);
        chk("overrun", 32'h1, {31'h0, overrunError});
        rdc(ssd_pkg::SHADOW_12, 32'h0000_0022);
        wr(CTRL, 32'h0000_0004);
        chk("overrun", 32'h0, {31'h0, overrunError});
    endtask
    task automatic t_tx_off();
        stall <= 1'b1;
        wr(BASE, 32'h1234_5633);
        chk("empty", 32'h0, {31'h0, txHoldingEmptyFlag});
        wr(BASE + 32'h0000_003c, 32'h0000_0044);
        stall <= 1'b0;
        wait_empty();
        chk("count", 32'h1, i_far.got.size());
        chk("byte", 32'h44, {24'h0, i_far.got[0]});
        i_far.got.delete();
    endtask
    task automatic t_rx_on();
        wr(CTRL, 32'h0000_0001);
        chk("fifo", 32'h1, {31'h0, fifoEnable});
        for (int i = 0; i <= DEP; i++) i_far.send(8'h40 + 8'(i));
        chk("overrun", 32'h1, {31'h0, overrunError});
        for (int i = 0; i < DEP; i++) rdc(BASE + 32'(4 * (15 - i)), 32'h40 + 32'(i));
        chk("ready", 32'h0, {31'h0, receiveDataReady});
    endtask
    task automatic t_tx_on();
        stall <= 1'b1;
        for (int i = 0; i <= DEP; i++) wr(BASE + 32'(4 * i), 32'h80 + 32'(i));
        stall <= 1'b0;
        wait_empty();
        chk("count", DEP, i_far.got.size());
        for (int i = 0; i < DEP; i++) chk("byte", 32'h80 + 32'(i), {24'h0, i_far.got[i]});
        i_far.got.delete();
        // infrared mode must still carry the byte out
        wr(CTRL, 32'h0000_0002);
        chk("ir", 32'h1, {31'h0, irMode});
        wr(ssd_pkg::SHADOW_12, 32'h0000_005a);
        wait_empty();
        chk("irbyte", 32'h5a, {24'h0, i_far.got[0]});
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_rx_off();
        t_tx_off();
        t_rx_on();
        t_tx_on();
        give_verdict();
    end
endmodule // tb_serial_shadow_data_port
